// ### shared/ssm_pkg.sv
package ssm_pkg;

   // register offsets, byte addresses of aligned 32-bit words
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FREQ = 8'h04;
   localparam logic [7:0] ADDR_GRAY = 8'h08;
   localparam logic [7:0] ADDR_LEN = 8'h0c;
   localparam logic [7:0] ADDR_REGW = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   localparam logic [7:0] ADDR_DLO = 8'h18;
   localparam logic [7:0] ADDR_DHI = 8'h1c;

   // control word fields
   localparam int CTRL_START = 0;
   localparam int CTRL_SSI = 1;
   localparam int CTRL_REGCYC = 2;
   localparam int CTRL_SLAVE_LSB = 4;

   // divider word fields
   localparam int FREQ_SENS_LSB = 0;
   localparam int FREQ_REG_LSB = 5;

   // length word fields
   localparam int LEN_DATA_LSB = 0;
   localparam int LEN_WR_LSB = 8;
   localparam int LEN_RD_LSB = 16;

   // reset values
   localparam logic [4:0] RST_SENS_DIV = 5'h00;
   localparam logic [2:0] RST_REG_DIV = 3'h0;
   localparam logic [7:0] RST_GRAY = 8'h00;
   localparam logic [6:0] RST_LEN_DATA = 7'h20;
   localparam logic [5:0] RST_LEN_WR = 6'h08;
   localparam logic [5:0] RST_LEN_RD = 6'h08;
   localparam logic [31:0] RST_REGW = 32'h0000_0000;

   // sensor divider decode: low codes step by 2, high codes by 20
   localparam logic [4:0] SENS_SPLIT = 5'h10;
   localparam logic [19:0] SENS_STEP_LO = 20'h2;
   localparam logic [19:0] SENS_STEP_HI = 20'h14;
   localparam logic [19:0] SENS_MIN = 20'h2;
   localparam logic [19:0] SENS_MAX = 20'h140;
   localparam logic [5:0] WR_MAX = 6'h20;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } ssm_bus_req_t;

   typedef struct packed {
      logic [7:0] ack_bits;
      logic err_ack;
      logic err_edge;
      logic done;
      logic busy;
   } ssm_status_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_EDGE,
      ST_ACK,
      ST_DATA,
      ST_REG_WR,
      ST_REG_RD,
      ST_STOP
   } ssm_state_t;

endpackage : ssm_pkg

// ### design/ssm_phase.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_phase (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic run, // count while high
   input wire logic restart, // back to phase zero
   input wire logic [19:0] period, // period in system clocks
   output logic [19:0] cnt, // current phase
   output logic wrap, // last cycle of the period
   output logic [3:0] point // four evenly spread sampling strobes
);

   logic [19:0] eighth;

   assign eighth = period >> 3;
   assign wrap = run && (cnt == period - 20'h1);

   // points sit at 1/8, 3/8, 5/8 and 7/8 of the period
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_pt
         assign point[i] = run && (cnt == 20'(eighth * 20'(2 * i + 1)));
      end
   endgenerate

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 20'h0;
      end else if (ce) begin
         if (restart) begin
            cnt <= 20'h0;
         end else if (run) begin
            cnt <= wrap ? 20'h0 : cnt + 20'h1;
         end
      end
   end

endmodule : ssm_phase
`default_nettype wire

// ### design/ssm_line_timing.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_line_timing #(
   parameter int DW = 64, // captured data width
   parameter int EDGE_LIMIT = 64, // clock periods waited for the slave edge
   parameter int ACK_LIMIT = 32 // acknowledge bits that raise a fault, one fewer is tolerated
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic resetn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire ssm_pkg::ssm_bus_req_t bus_req, // register port request
   output logic [31:0] bus_rdata, // read data, cycle after the strobe
   output logic master_clock_out, // clock line toward the slaves
   input wire logic slave_data_in // returning data line, asynchronous
);

   ssm_pkg::ssm_state_t st;
   ssm_pkg::ssm_status_t stat;
   logic ctrl_ssi, ctrl_regcyc;
   logic [2:0] ctrl_slave, register_freq_divider;
   logic [4:0] sensor_freq_divider;
   logic [7:0] gray_decode_enable;
   logic [6:0] len_data, f_len;
   logic [5:0] len_wr, len_rd, f_wlen, f_rlen, wcnt, wl;
   logic [31:0] reg_wdata, wshift;
   logic f_ssi, f_gray, s1, s2, s3, fall;
   logic [19:0] f_sp, f_rp, cur_p, hi_len, ck_cnt, rx_cnt, high_run, pt_gap;
   logic ck_wrap, rx_wrap, active, rise, next_ma, start_go;
   logic [3:0] rx_pt;
   logic samp1, samp2, rx_prev, rx_bit, bit_raw, bit_val, gray_acc, ssi_armed;
   logic take, bit_last, wr_last, edge_to, ack_to, to_stop, hb_bit;
   logic [15:0] per_cnt;
   logic [6:0] bcnt;
   logic [DW-1:0] rx_shift;
   ssm_pkg::ssm_state_t hb_st;

   function automatic logic [19:0] sens_period(input logic [4:0] f);
      if (f < ssm_pkg::SENS_SPLIT) begin
         sens_period = ssm_pkg::SENS_STEP_LO * (20'(f) + 20'h1);
      end else begin
         sens_period = ssm_pkg::SENS_STEP_HI * (20'(f) - 20'(ssm_pkg::SENS_SPLIT) + 20'h1);
      end
   endfunction : sens_period

   // ---------------- register port ----------------
   assign start_go = ce && bus_req.we && (bus_req.addr == ssm_pkg::ADDR_CTRL)
                     && bus_req.wdata[ssm_pkg::CTRL_START] && (st == ssm_pkg::ST_IDLE);
   assign wl = (len_wr > ssm_pkg::WR_MAX) ? ssm_pkg::WR_MAX : len_wr;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ssi <= 1'b0;
         ctrl_regcyc <= 1'b0;
         ctrl_slave <= 3'h0;
         sensor_freq_divider <= ssm_pkg::RST_SENS_DIV;
         register_freq_divider <= ssm_pkg::RST_REG_DIV;
         gray_decode_enable <= ssm_pkg::RST_GRAY;
         len_data <= ssm_pkg::RST_LEN_DATA;
         len_wr <= ssm_pkg::RST_LEN_WR;
         len_rd <= ssm_pkg::RST_LEN_RD;
         reg_wdata <= ssm_pkg::RST_REGW;
      end else if (ce && bus_req.we) begin
         case (bus_req.addr)
            ssm_pkg::ADDR_CTRL: begin
               ctrl_ssi <= bus_req.wdata[ssm_pkg::CTRL_SSI];
               ctrl_regcyc <= bus_req.wdata[ssm_pkg::CTRL_REGCYC];
               ctrl_slave <= bus_req.wdata[ssm_pkg::CTRL_SLAVE_LSB +: 3];
            end
            ssm_pkg::ADDR_FREQ: begin
               sensor_freq_divider <= bus_req.wdata[ssm_pkg::FREQ_SENS_LSB +: 5];
               register_freq_divider <= bus_req.wdata[ssm_pkg::FREQ_REG_LSB +: 3];
            end
            ssm_pkg::ADDR_GRAY: gray_decode_enable <= bus_req.wdata[7:0];
            ssm_pkg::ADDR_LEN: begin
               len_data <= bus_req.wdata[ssm_pkg::LEN_DATA_LSB +: 7];
               len_wr <= bus_req.wdata[ssm_pkg::LEN_WR_LSB +: 6];
               len_rd <= bus_req.wdata[ssm_pkg::LEN_RD_LSB +: 6];
            end
            ssm_pkg::ADDR_REGW: reg_wdata <= bus_req.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata <= 32'h0;
      end else if (ce) begin
         bus_rdata <= 32'h0;
         if (bus_req.re) begin
            case (bus_req.addr)
               ssm_pkg::ADDR_CTRL: bus_rdata <= {25'h0, ctrl_slave, 1'b0, ctrl_regcyc,
                                                 ctrl_ssi, 1'b0};
               ssm_pkg::ADDR_FREQ: bus_rdata <= {24'h0, register_freq_divider,
                                                 sensor_freq_divider};
               ssm_pkg::ADDR_GRAY: bus_rdata <= {24'h0, gray_decode_enable};
               ssm_pkg::ADDR_LEN: bus_rdata <= {10'h0, len_rd, 2'h0, len_wr, 1'h0, len_data};
               ssm_pkg::ADDR_REGW: bus_rdata <= reg_wdata;
               ssm_pkg::ADDR_STAT: bus_rdata <= {20'h0, stat};
               ssm_pkg::ADDR_DLO: bus_rdata <= rx_shift[31:0];
               ssm_pkg::ADDR_DHI: bus_rdata <= rx_shift[DW-1:32];
               default: bus_rdata <= 32'h0;
            endcase
         end
      end
   end

   // ---------------- frame setup, latched at start ----------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         f_ssi <= 1'b0;
         f_gray <= 1'b0;
         f_sp <= ssm_pkg::SENS_MIN;
         f_rp <= ssm_pkg::SENS_MIN;
         f_len <= ssm_pkg::RST_LEN_DATA;
         f_wlen <= ssm_pkg::RST_LEN_WR;
         f_rlen <= ssm_pkg::RST_LEN_RD;
      end else if (start_go) begin
         f_ssi <= bus_req.wdata[ssm_pkg::CTRL_SSI];
         f_gray <= gray_decode_enable[bus_req.wdata[ssm_pkg::CTRL_SLAVE_LSB +: 3]];
         f_sp <= sens_period(sensor_freq_divider);
         f_rp <= 20'(sens_period(sensor_freq_divider)
                     << (4'(register_freq_divider) + 4'h1));
         f_len <= len_data;
         f_wlen <= wl;
         f_rlen <= len_rd;
      end
   end

   // ---------------- clock output generation ----------------
   assign active = (st != ssm_pkg::ST_IDLE) && (st != ssm_pkg::ST_STOP);
   assign cur_p = (st == ssm_pkg::ST_REG_WR || st == ssm_pkg::ST_REG_RD) ? f_rp : f_sp;

   always_comb begin
      case (st)
         ssm_pkg::ST_REG_WR: begin
            hi_len = wshift[31] ? 20'(3 * (cur_p >> 2)) : (cur_p >> 2);
         end
         default: hi_len = cur_p >> 1;
      endcase
   end

   assign rise = active && (ck_cnt == cur_p - hi_len);
   assign next_ma = active ? (ck_cnt >= cur_p - hi_len) : 1'b1;

   ssm_phase u_clk_ph (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .run(st != ssm_pkg::ST_IDLE),
      .restart(start_go || (to_stop && st != ssm_pkg::ST_STOP)),
      .period(cur_p),
      .cnt(ck_cnt),
      .wrap(ck_wrap),
      .point()
   );

   // bit timing for BiSS reception, aligned to the slave's falling edge
   ssm_phase u_rx_ph (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .run(!f_ssi && (st == ssm_pkg::ST_ACK || st == ssm_pkg::ST_DATA)),
      .restart(fall && st == ssm_pkg::ST_WAIT_EDGE),
      .period(f_sp),
      .cnt(rx_cnt),
      .wrap(rx_wrap),
      .point(rx_pt)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         master_clock_out <= 1'b1;
         high_run <= 20'h0;
         hb_bit <= 1'b0;
         hb_st <= ssm_pkg::ST_IDLE;
      end else if (ce) begin
         master_clock_out <= next_ma;
         high_run <= master_clock_out ? high_run + 20'h1 : 20'h0;
         if (next_ma) begin
            hb_bit <= wshift[31];
            hb_st <= st;
         end
      end
   end

   // ---------------- data line synchroniser and edge ----------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else if (ce) begin
         s1 <= slave_data_in;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign fall = s3 && !s2;

   // ---------------- bit decisions ----------------
   // a split vote keeps the last settled level rather than guessing on a transition
   assign rx_bit = (samp1 == samp2) ? samp1 : rx_prev;
   assign bit_raw = (st == ssm_pkg::ST_DATA && !f_ssi) ? rx_bit : s2;
   assign bit_val = (f_ssi && f_gray) ? (gray_acc ^ bit_raw) : bit_raw;
   // ssi data is taken at rising edges; the slave may lag by up to one period
   assign take = (st == ssm_pkg::ST_DATA
                  && (f_ssi ? (rise && ssi_armed) : rx_wrap))
                 || (st == ssm_pkg::ST_REG_RD && rise);
   assign bit_last = 7'(bcnt + 7'h1) >= ((st == ssm_pkg::ST_REG_RD) ? {1'b0, f_rlen} : f_len);
   assign wr_last = (st == ssm_pkg::ST_REG_WR) && ck_wrap && (6'(wcnt + 6'h1) >= f_wlen);
   assign edge_to = (st == ssm_pkg::ST_WAIT_EDGE) && ck_wrap && !fall
                    && (per_cnt == 16'(EDGE_LIMIT - 1));
   assign ack_to = (st == ssm_pkg::ST_ACK) && rx_wrap && !rx_bit
                   && (stat.ack_bits == 8'(ACK_LIMIT - 1));
   assign to_stop = edge_to || ack_to || (take && bit_last) || (wr_last && f_rlen == 6'h0);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         samp1 <= 1'b0;
         samp2 <= 1'b0;
         rx_prev <= 1'b0;
      end else if (ce) begin
         if (fall && st == ssm_pkg::ST_WAIT_EDGE) begin
            rx_prev <= 1'b0;
         end else if (rx_wrap) begin
            rx_prev <= rx_bit;
         end
         if (rx_pt[1]) begin
            samp1 <= s2;
         end
         if (rx_pt[2]) begin
            samp2 <= s2;
         end
      end
   end

   // ---------------- sequence ----------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= ssm_pkg::ST_IDLE;
      end else if (ce) begin
         case (st)
            ssm_pkg::ST_IDLE: begin
               if (start_go) begin
                  if (bus_req.wdata[ssm_pkg::CTRL_SSI]) begin
                     st <= ssm_pkg::ST_DATA;
                  end else if (bus_req.wdata[ssm_pkg::CTRL_REGCYC]) begin
                     st <= ssm_pkg::ST_REG_WR;
                  end else begin
                     st <= ssm_pkg::ST_WAIT_EDGE;
                  end
               end
            end
            ssm_pkg::ST_WAIT_EDGE: begin
               if (fall) begin
                  st <= ssm_pkg::ST_ACK;
               end else if (to_stop) begin
                  st <= ssm_pkg::ST_STOP;
               end
            end
            ssm_pkg::ST_ACK: begin
               if (rx_wrap && rx_bit) begin
                  st <= ssm_pkg::ST_DATA;
               end else if (to_stop) begin
                  st <= ssm_pkg::ST_STOP;
               end
            end
            ssm_pkg::ST_REG_WR: begin
               if (wr_last) begin
                  st <= (f_rlen == 6'h0) ? ssm_pkg::ST_STOP : ssm_pkg::ST_REG_RD;
               end
            end
            ssm_pkg::ST_DATA, ssm_pkg::ST_REG_RD: begin
               if (to_stop) begin
                  st <= ssm_pkg::ST_STOP;
               end
            end
            ssm_pkg::ST_STOP: begin
               if (ck_wrap) begin
                  st <= ssm_pkg::ST_IDLE;
               end
            end
            default: st <= ssm_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         per_cnt <= 16'h0;
         bcnt <= 7'h0;
         wcnt <= 6'h0;
         wshift <= 32'h0;
         ssi_armed <= 1'b0;
      end else if (ce) begin
         if (start_go) begin
            per_cnt <= 16'h0;
            bcnt <= 7'h0;
            wcnt <= 6'h0;
            wshift <= reg_wdata << (ssm_pkg::WR_MAX - wl);
            ssi_armed <= 1'b0;
         end else begin
            if (st == ssm_pkg::ST_WAIT_EDGE && ck_wrap) begin
               per_cnt <= per_cnt + 16'h1;
            end
            if (st == ssm_pkg::ST_REG_WR && ck_wrap) begin
               wcnt <= wcnt + 6'h1;
               wshift <= wshift << 1;
            end
            // the first rising edge only tells the slave to latch its word
            if (rise && f_ssi) begin
               ssi_armed <= 1'b1;
            end
            if (take) begin
               bcnt <= bcnt + 7'h1;
            end else if (wr_last) begin
               bcnt <= 7'h0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_shift <= '0;
         gray_acc <= 1'b0;
      end else if (ce) begin
         if (start_go) begin
            rx_shift <= '0;
            gray_acc <= 1'b0;
         end else if (take) begin
            rx_shift <= {rx_shift[DW-2:0], bit_val};
            gray_acc <= bit_val;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat.done <= 1'b0;
         stat.err_edge <= 1'b0;
         stat.err_ack <= 1'b0;
         stat.ack_bits <= 8'h0;
         stat.busy <= 1'b0;
      end else if (ce) begin
         // taken from the next state so the flag tracks the live state exactly
         stat.busy <= start_go
                      || (st != ssm_pkg::ST_IDLE && !(st == ssm_pkg::ST_STOP && ck_wrap));
         if (start_go) begin
            stat.done <= 1'b0;
            stat.err_edge <= 1'b0;
            stat.err_ack <= 1'b0;
            stat.ack_bits <= 8'h0;
         end
         if (st == ssm_pkg::ST_ACK && rx_wrap && !rx_bit) begin
            stat.ack_bits <= stat.ack_bits + 8'h1;
         end
         if (edge_to) begin
            stat.err_edge <= 1'b1;
         end
         if (ack_to) begin
            stat.err_ack <= 1'b1;
         end
         if (st == ssm_pkg::ST_STOP && ck_wrap) begin
            stat.done <= 1'b1;
         end
      end
   end

   // ---------------- checks ----------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pt_gap <= 20'h0;
      end else if (ce) begin
         pt_gap <= rx_pt[1] ? 20'h1 : pt_gap + 20'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !ce);

   // an edge timeout ends the frame with the line high, so that wrap is left out
   wait_toggle_a: assert property (
      (st == ssm_pkg::ST_WAIT_EDGE && ck_wrap && !edge_to)
      |=> ##1 !master_clock_out && $stable(rx_shift))
      else $error("clock not toggling while waiting for edge");
   point_gap_a: assert property (
      (rx_pt[2] && !rx_pt[1] && (f_sp >> 3) != 20'h0)
      |-> pt_gap == 20'((f_sp >> 3) << 1))
      else $error("sampling points not evenly spaced");
   ack_entry_a: assert property (
      (st == ssm_pkg::ST_WAIT_EDGE && fall)
      |=> st == ssm_pkg::ST_ACK && rx_cnt == 20'h0)
      else $error("acknowledge not entered at falling edge");
   mid_vote_a: assert property (
      (st == ssm_pkg::ST_DATA && !f_ssi && rx_wrap && samp1 == samp2)
      |=> rx_shift[0] == $past(samp1))
      else $error("bit not decided from mid samples");
   ssi_rise_a: assert property (
      ($changed(bcnt) && $past(st == ssm_pkg::ST_DATA && f_ssi))
      |-> $past(rise))
      else $error("ssi bit taken off the rising edge");
   reg_period_a: assert property (
      (st == ssm_pkg::ST_REG_WR || st == ssm_pkg::ST_REG_RD)
      |-> f_rp >= (f_sp << 1) && f_rp <= (f_sp << 8) && ck_cnt < f_rp)
      else $error("register period out of range");
   wr_zero_a: assert property (
      ($fell(master_clock_out) && hb_st == ssm_pkg::ST_REG_WR && !hb_bit)
      |-> high_run == (f_rp >> 2))
      else $error("zero bit high time wrong");
   wr_one_a: assert property (
      ($fell(master_clock_out) && hb_st == ssm_pkg::ST_REG_WR && hb_bit)
      |-> high_run == 20'(3 * (f_rp >> 2)))
      else $error("one bit high time wrong");
   rd_half_a: assert property (
      ($fell(master_clock_out) && hb_st == ssm_pkg::ST_REG_RD)
      |-> high_run == (f_rp >> 1))
      else $error("readback high time wrong");
   sens_range_a: assert property (
      (st != ssm_pkg::ST_IDLE)
      |-> f_sp >= ssm_pkg::SENS_MIN && f_sp <= ssm_pkg::SENS_MAX && !f_sp[0])
      else $error("sensor period out of range");
   ssi_sym_a: assert property (
      ($fell(master_clock_out) && hb_st == ssm_pkg::ST_DATA && f_ssi)
      |-> high_run == (f_sp >> 1))
      else $error("ssi clock not symmetric");
   mode_sel_a: assert property (
      (st == ssm_pkg::ST_WAIT_EDGE || st == ssm_pkg::ST_ACK || st == ssm_pkg::ST_REG_WR)
      |-> !f_ssi)
      else $error("biss state entered in ssi mode");
   gray_off_a: assert property (
      (take && !f_ssi)
      |=> rx_shift[0] == $past(bit_raw))
      else $error("gray conversion applied outside ssi");

endmodule : ssm_line_timing
`default_nettype wire

// ### tb/ssm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_slave_model (
   input wire logic clk, // system clock
   input wire logic line_clk, // clock line from the master
   input wire logic ssi, // ssi behaviour when high
   input wire logic [3:0] lat, // biss periods before the ack
   input wire logic [3:0] acks, // biss ack bits
   input wire logic [7:0] word, // data sent msb first
   output logic data_out // returning data line, idles high
);
   int n = 0;
   int idle = 0;
   logic prev = 1'b1;
   logic line = 1'b1;
   assign data_out = line;
   // a long high on the clock line ends the frame, as a slave timeout would
   always @(posedge clk) begin
      prev <= line_clk;
      idle <= line_clk ? idle + 1 : 0;
      if (idle > 400) begin
         n <= 0;
         line <= 1'b1;
      end else if (line_clk && !prev) begin
         n <= n + 1;
         if (ssi)
            line <= (n < 8) ? word[7 - n] : 1'b1;
         else if (n < lat + acks)
            line <= (n < lat);
         else if (n == lat + acks)
            line <= 1'b1;
         else if (n - lat - acks <= 8)
            line <= word[8 - (n - lat - acks)];
         else
            line <= 1'b1;
      end
   end
endmodule : ssm_slave_model
`default_nettype wire

// ### tb/ssm_line_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_line_timing_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   ssm_pkg::ssm_bus_req_t req = '0;
   logic [31:0] rdata;
   logic [31:0] d = '0;
   logic mclk;
   logic sdata;
   logic mprev = 1'b1;
   logic mssi = 1'b0;
   logic [3:0] acks = 4'h2;
   logic [7:0] word = 8'hc6;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int run = 0;
   int hq[$];
   int lq[$];

   ssm_line_timing #(.EDGE_LIMIT(8), .ACK_LIMIT(4)) DUT (.clk(clk), .resetn(resetn), .ce(1'b1),
      .bus_req(req), .bus_rdata(rdata), .master_clock_out(mclk), .slave_data_in(sdata));
   ssm_slave_model slave (.clk(clk), .line_clk(mclk), .ssi(mssi), .lat(4'h2), .acks(acks),
      .word(word), .data_out(sdata));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
      @(posedge clk);
      req.we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk);
      req.re <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // idle gap lets the slave model time out, then start and poll for done
   task automatic frame(input logic [31:0] ctrl);
      repeat (450) @(posedge clk);
      #1;
      hq.delete();
      lq.delete();
      d = '0;
      wr(ssm_pkg::ADDR_CTRL, ctrl | 32'h1);
      for (int i = 0; i < 3000 && d[1] !== 1'b1; i++) rd(ssm_pkg::ADDR_STAT);
      chk(d[1], 1'b1);
   endtask : frame

   initial forever #5 clk = ~clk;

   // high and low run lengths of the clock line, in system clocks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      mprev <= mclk;
      run <= (mclk == mprev) ? run + 1 : 1;
      if (mclk != mprev && mprev) hq.push_back(run);
      if (mclk != mprev && !mprev) lq.push_back(run);
      if (cyc == 30000) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      int p;
      int pr;
      int h;
      int n;
      logic [3:0] w;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      mssi <= 1'b1;
      wr(ssm_pkg::ADDR_GRAY, 32'h2);
      wr(ssm_pkg::ADDR_LEN, 32'h0008_0808);
      for (int i = 0; i < 2; i++) begin
         p = i ? 320 : 8;
         wr(ssm_pkg::ADDR_FREQ, i ? 32'h1f : 32'h3);
         rd(ssm_pkg::ADDR_FREQ);
         chk(d, i ? 32'h1f : 32'h3);
         frame(i ? 32'h2 : 32'h12);
         rd(ssm_pkg::ADDR_DLO);
         chk(d[7:0], i ? 8'hc6 : 8'h84);
         for (int k = 1; k < hq.size(); k++) chk(hq[k], p / 2);
         for (int k = 0; k < lq.size(); k++) chk(lq[k], p / 2);
         $display("ssi test %0d done", i);
      end
      mssi <= 1'b0;
      wr(ssm_pkg::ADDR_FREQ, 32'h3);
      wr(ssm_pkg::ADDR_GRAY, 32'h1);
      for (int i = 0; i < 3; i++) begin
         acks <= i == 0 ? 4'h2 : i == 1 ? 4'h0 : 4'hf;
         word <= i == 1 ? 8'hff : 8'ha5;
         frame(32'h0);
         chk(d[3:0], i == 0 ? 4'h2 : i == 1 ? 4'h6 : 4'ha);
         chk(d[11:4], i == 0 ? 8'h2 : i == 1 ? 8'h0 : 8'h4);
         for (int k = 1; k < hq.size(); k++) chk(hq[k], 4);
         if (i == 1) chk(hq.size() > 6, 1'b1);
         rd(ssm_pkg::ADDR_DLO);
         if (i == 0) chk(d[7:0], 8'ha5);
         $display("biss test %0d done", i);
      end
      for (int i = 0; i < 2; i++) begin
         w = i ? 4'h1 : 4'hd;
         n = i ? 1 : 4;
         pr = i ? 2 << 8 : 8 << 1;
         wr(ssm_pkg::ADDR_FREQ, i ? 32'he0 : 32'h3);
         wr(ssm_pkg::ADDR_LEN, i ? 32'h0002_0108 : 32'h0002_0408);
         wr(ssm_pkg::ADDR_REGW, {28'h0, w});
         frame(32'h4);
         chk(hq.size(), n + 2);
         for (int k = 1; k <= n + 2; k++) begin
            h = k > n ? pr / 2 : w[n - k] ? pr * 3 / 4 : pr / 4;
            if (k < n + 2) chk(hq[k], h);
            chk(lq[k - 1], pr - h);
         end
         $display("register test %0d done", i);
      end
      stop_test();
   end
endmodule : ssm_line_timing_tb
`default_nettype wire
